// >>> logic/cam_monitor.sv
// Cabinet activity watchdog and 24 V supply monitor with latched faults
`timescale 1ns/1ps

// Behaviour
// - Fail when activity input has not changed level for 1.5 s.
// - Any activity edge restarts the inactivity timer while not failed.
// - Watchdog fault clears only by unit reset or line voltage inhibit.
// - Watchdog fault lights the activity lamp until unit reset.
// - Line low for 50 ms inhibits the watchdog.
// - Line good for 50 ms re-activates the watchdog.
// - Supply at or below 18 V for 500 ms causes failure.
// - Supply at or above 22 V never causes failure.
// - Supply dips of 200 ms or less are filtered out.
// - Supply fault lights the supply lamp until unit reset.
// - Supply fault clears only by unit reset.
// - Relay coil energised when not failed, released when failed.
// - Front panel reset press returns everything to non-failed, except a supply fault while the supply is still at or below 18 V.
// - External activity reset from power distribution assembly is ignored.
// - Failure contact is open in the failed state.
module cam_monitor
   import cam_pkg::*;
#(
   // Clock cycles per millisecond tick; shortened only to exercise the long durations
   parameter int unsigned TICK_DIV = TICK_CYC
)
(
   // Clock and power-on reset
   input wire logic mclk,
   input wire logic reset_n,
   // Controller activity line and ignored external reset
   input wire logic activity_input,
   input wire logic external_activity_reset,
   // Comparator inputs: line above 103 V, line below 98 V, supply at or below 18 V, supply below 22 V
   input wire logic line_good,
   input wire logic line_low,
   input wire logic supply_le_18v,
   input wire logic supply_lt_22v,
   // Front panel reset switch, high while pressed
   input wire logic panel_reset,
   // Lamps and relay
   output logic activity_fault_lamp,
   output logic supply_low_lamp,
   output logic remote_fault_lamp,
   output logic relay_coil,
   output logic fail_contact_closed
);
   ////////////////////////////////////////////////////////////////////////////////
   // Timebase and input edge detection
   logic tick;
   logic act_q;
   logic press_q;
   logic act_edge;
   logic unit_reset;
   logic ext_unused;

   cam_timebase #(
      .TICK_DIV(TICK_DIV)
   ) u_tb (
      .mclk(mclk),
      .reset_n(reset_n),
      .tick(tick)
   );

   assign act_edge = activity_input ^ act_q;
   // One shot on the press so a stuck switch resets only once
   assign unit_reset = panel_reset & ~press_q;
   assign ext_unused = external_activity_reset;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         act_q <= 1'b0;
         press_q <= 1'b0;
      end else begin
         act_q <= activity_input;
         press_q <= panel_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Saturating millisecond counter step
   function automatic logic [MS_W-1:0] step(input logic [MS_W-1:0] c, input logic run, input logic t,
                                            input logic [MS_W-1:0] lim);
      if (!run)
         step = '0;
      else if (t && c < lim)
         step = c + MS_W'(1);
      else
         step = c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Line voltage inhibit filter
   logic inhibit_q;
   logic inhibit_d;
   logic [MS_W-1:0] low_cnt_q;
   logic [MS_W-1:0] low_cnt_d;
   logic [MS_W-1:0] good_cnt_q;
   logic [MS_W-1:0] good_cnt_d;

   assign low_cnt_d = step(low_cnt_q, line_low & ~inhibit_q, tick, INHIBIT_TICKS);
   assign good_cnt_d = step(good_cnt_q, line_good & inhibit_q, tick, ENABLE_TICKS);
   assign inhibit_d = inhibit_q ? (good_cnt_q != ENABLE_TICKS) : (low_cnt_q == INHIBIT_TICKS);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_q <= '0;
         good_cnt_q <= '0;
         inhibit_q <= 1'b0;
      end else begin
         low_cnt_q <= low_cnt_d;
         good_cnt_q <= good_cnt_d;
         inhibit_q <= inhibit_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Activity watchdog state machine
   cam_wd_state_t wd_q;
   cam_wd_state_t wd_d;
   logic [MS_W-1:0] act_cnt_q;
   logic [MS_W-1:0] act_cnt_d;
   logic act_timeout;
   logic wd_fault;

   assign act_timeout = (act_cnt_q == ACT_TIMEOUT_TICKS);
   assign act_cnt_d = step(act_cnt_q, (wd_q == CAM_ARMED) & ~act_edge, tick, ACT_TIMEOUT_TICKS);
   assign wd_fault = (wd_q == CAM_TRIPPED);

   always_comb begin
      wd_d = wd_q;
      unique case (wd_q)
         CAM_ARMED: begin
            if (inhibit_q)
               wd_d = CAM_INHIBITED;
            else if (act_timeout)
               wd_d = CAM_TRIPPED;
         end
         CAM_INHIBITED: begin
            if (!inhibit_q)
               wd_d = CAM_ARMED;
         end
         CAM_TRIPPED: begin
            if (unit_reset)
               wd_d = CAM_ARMED;
            else if (inhibit_q)
               wd_d = CAM_INHIBITED;
         end
         default: wd_d = CAM_ARMED;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wd_q <= CAM_ARMED;
         act_cnt_q <= '0;
      end else begin
         wd_q <= wd_d;
         act_cnt_q <= act_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Supply monitor
   logic [MS_W-1:0] sup_cnt_q;
   logic [MS_W-1:0] sup_cnt_d;
   logic sup_fault_q;
   logic sup_fault_d;
   logic sup_low;

   // Below 22 V gate keeps 22 V and above from ever counting
   assign sup_low = supply_le_18v & supply_lt_22v;
   assign sup_cnt_d = step(sup_cnt_q, sup_low, tick, SUPPLY_FAIL_TICKS);
   // Set wins over the reset press
   assign sup_fault_d = (sup_cnt_q == SUPPLY_FAIL_TICKS) | (sup_fault_q & ~unit_reset);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sup_cnt_q <= '0;
         sup_fault_q <= 1'b0;
      end else begin
         sup_cnt_q <= sup_cnt_d;
         sup_fault_q <= sup_fault_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Lamps and relay
   logic act_lamp_d;
   logic failed_d;

   // Lamp follows the next state so it lights on the same edge as the relay drops
   assign act_lamp_d = (wd_d == CAM_TRIPPED) | wd_fault & ~unit_reset | (activity_fault_lamp & ~unit_reset);
   assign failed_d = (wd_d == CAM_TRIPPED) | sup_fault_d;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         activity_fault_lamp <= LAMP_RESET;
         remote_fault_lamp <= LAMP_RESET;
         supply_low_lamp <= LAMP_RESET;
         relay_coil <= RELAY_RESET;
         fail_contact_closed <= RELAY_RESET;
      end else begin
         activity_fault_lamp <= act_lamp_d;
         remote_fault_lamp <= act_lamp_d;
         supply_low_lamp <= sup_fault_d;
         relay_coil <= ~failed_d;
         fail_contact_closed <= ~failed_d;
      end
   end
endmodule // cam_monitor

// >>> logic/cam_pkg.sv
// Constants for the cabinet activity and supply monitor
package cam_pkg;
   // Clock and timebase
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned TICK_W = 15;
   // Durations in milliseconds, counted in 1 ms ticks
   localparam int unsigned ACT_TIMEOUT_MS = 1500;
   localparam int unsigned INHIBIT_MS = 50;
   localparam int unsigned ENABLE_MS = 50;
   localparam int unsigned SUPPLY_FAIL_MS = 500;
   localparam int unsigned MS_W = 11;
   localparam logic [MS_W-1:0] ACT_TIMEOUT_TICKS = MS_W'(ACT_TIMEOUT_MS);
   localparam logic [MS_W-1:0] INHIBIT_TICKS = MS_W'(INHIBIT_MS);
   localparam logic [MS_W-1:0] ENABLE_TICKS = MS_W'(ENABLE_MS);
   localparam logic [MS_W-1:0] SUPPLY_FAIL_TICKS = MS_W'(SUPPLY_FAIL_MS);
   // Reset values
   localparam logic RELAY_RESET = 1'b0;
   localparam logic LAMP_RESET = 1'b0;
   typedef enum logic [1:0] {CAM_ARMED, CAM_INHIBITED, CAM_TRIPPED} cam_wd_state_t;
endpackage

// >>> logic/cam_timebase.sv
// Free running timebase that emits a one-cycle tick every millisecond
`timescale 1ns/1ps
module cam_timebase
   import cam_pkg::*;
#(
   // Clock cycles per millisecond tick
   parameter int unsigned TICK_DIV = TICK_CYC
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Tick out
   output logic tick
);
   logic [TICK_W-1:0] cnt_q;
   logic [TICK_W-1:0] cnt_d;
   logic wrap;

   assign wrap = (cnt_q == TICK_W'(TICK_DIV - 1));
   assign cnt_d = wrap ? '0 : cnt_q + TICK_W'(1);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick <= wrap;
      end
   end
endmodule // cam_timebase

// >>> tb/cam_monitor_properties.sv
// Timing and latching properties of the cabinet monitor outputs
`timescale 1ns/1ps
module cam_monitor_properties
   import cam_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYC
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Inputs
   input wire logic activity_input,
   input wire logic external_activity_reset,
   input wire logic line_good,
   input wire logic line_low,
   input wire logic supply_le_18v,
   input wire logic supply_lt_22v,
   input wire logic panel_reset,
   // Outputs
   input wire logic activity_fault_lamp,
   input wire logic supply_low_lamp,
   input wire logic remote_fault_lamp,
   input wire logic relay_coil,
   input wire logic fail_contact_closed
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   localparam int unsigned ACT_MIN = (ACT_TIMEOUT_MS - 100) * TICK_DIV;
   localparam int unsigned SUP_MIN = (SUPPLY_FAIL_MS - 1) * TICK_DIV;
   logic act_prev_q;
   int unsigned act_cnt_q;
   int unsigned sup_cnt_q;
   // Cycles since the last activity edge and since the supply went low
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         act_prev_q <= 1'b0;
         act_cnt_q <= 0;
         sup_cnt_q <= 0;
      end else begin
         act_prev_q <= activity_input;
         act_cnt_q <= (activity_input != act_prev_q) ? 0 : act_cnt_q + 1;
         sup_cnt_q <= (supply_le_18v && supply_lt_22v) ? sup_cnt_q + 1 : 0;
      end
   end
   sequence s_press;
      $past(panel_reset, 1) || $past(panel_reset, 2);
   endsequence
   a_relay_contact_match: assert property (relay_coil == fail_contact_closed)
      else $error("relay and contact disagree");
   a_remote_lamp_copy: assert property (remote_fault_lamp == activity_fault_lamp)
      else $error("remote lamp differs");
   a_supply_lamp_relay: assert property (supply_low_lamp |-> !relay_coil)
      else $error("relay energised with supply fault");
   a_relay_drop_cause: assert property ($fell(relay_coil) |-> activity_fault_lamp || supply_low_lamp)
      else $error("relay dropped without fault");
   a_act_lamp_hold: assert property ($fell(activity_fault_lamp) |-> s_press)
      else $error("activity lamp cleared without panel reset");
   a_sup_lamp_hold: assert property ($fell(supply_low_lamp) |-> s_press)
      else $error("supply lamp cleared without panel reset");
   a_sup_fail_time: assert property ($rose(supply_low_lamp) |-> sup_cnt_q >= SUP_MIN)
      else $error("supply fault too early");
   a_act_fail_time: assert property ($rose(activity_fault_lamp) |-> act_cnt_q >= ACT_MIN)
      else $error("activity fault too early");
endmodule // cam_monitor_properties
bind cam_monitor cam_monitor_properties #(.TICK_DIV(TICK_DIV)) u_props (.*);

// >>> tb/cam_ctrl_model.sv
// Controller model toggling the activity line, fast or slow
`timescale 1ns/1ps
module cam_ctrl_model (
   input wire logic mclk,
   input wire logic run,
   input wire logic slow,
   output logic activity_input
);
   int unsigned gap;
   initial begin
      activity_input = 1'b0;
      gap = 0;
   end
   always @(negedge mclk) begin
      if (run && gap == 0) begin
         activity_input <= ~activity_input;
         gap = slow ? 2000 + $urandom_range(999) : $urandom_range(20);
      end else if (run) begin
         gap = gap - 1;
      end
   end
endmodule // cam_ctrl_model

// >>> tb/cam_monitor_tb_top.sv
// Self-checking bench for the cabinet monitor
`timescale 1ns/1ps
module cam_monitor_tb_top;
   import cam_pkg::*;
   logic mclk = 1'b0, reset_n = 1'b0, ext_rst = 1'b0, lg = 1'b1, ll = 1'b0, s18 = 1'b0, s22 = 1'b0;
   logic pr = 1'b0, run = 1'b1, slow = 1'b0, act;
   logic afl, sll, rfl, coil, cont;
   int n_fail = 0, n_compared = 0, cyc = 0;
   // Short millisecond tick so the long durations fit in the run
   localparam int unsigned TB_TICK = 4;
   always #25 mclk = ~mclk;
   cam_ctrl_model ctrl (.mclk(mclk), .run(run), .slow(slow), .activity_input(act));
   cam_monitor #(.TICK_DIV(TB_TICK)) uut (.mclk(mclk), .reset_n(reset_n), .activity_input(act),
      .external_activity_reset(ext_rst),
      .line_good(lg), .line_low(ll), .supply_le_18v(s18), .supply_lt_22v(s22), .panel_reset(pr),
      .activity_fault_lamp(afl), .supply_low_lamp(sll), .remote_fault_lamp(rfl), .relay_coil(coil),
      .fail_contact_closed(cont));
   function automatic logic sup_fault(int unsigned c);
      return c >= SUPPLY_FAIL_MS * TB_TICK;
   endfunction
   function automatic logic sup_known(int unsigned c);
      return c < (SUPPLY_FAIL_MS - 1) * TB_TICK || sup_fault(c);
   endfunction
   task automatic chk(string nm, logic e, logic g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic outs(logic wd, logic sp);
      chk("activity_fault_lamp", wd, afl);
      chk("remote_fault_lamp", wd, rfl);
      chk("supply_low_lamp", sp, sll);
      chk("relay_coil", !(wd | sp), coil);
      chk("fail_contact_closed", !(wd | sp), cont);
   endtask
   task automatic press();
      pr = 1'b0;
      @(negedge mclk) pr = 1'b1;
      @(negedge mclk) pr = 1'b0;
      @(negedge mclk);
   endtask
   task automatic do_reset();
      @(negedge mclk) reset_n = 1'b0;
      repeat (8) @(negedge mclk);
      chk("relay_coil", 1'b0, coil);
      chk("fail_contact_closed", 1'b0, cont);
      chk("activity_fault_lamp", 1'b0, afl);
      chk("remote_fault_lamp", 1'b0, rfl);
      chk("supply_low_lamp", 1'b0, sll);
      reset_n = 1'b1;
      repeat (2) @(negedge mclk);
      outs(1'b0, 1'b0);
   endtask
   task automatic test_done();
      if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      void'($urandom(45));
      do_reset();
      repeat (20000) begin
         @(negedge mclk);
         ext_rst = 1'($urandom_range(1));
         pr = ($urandom_range(199) == 0);
         ll = ($urandom_range(9) == 0);
         lg = !ll;
         s22 = ($urandom_range(3) == 0);
         s18 = s22 & 1'($urandom_range(1));
         outs(1'b0, 1'b0);
      end
      pr = 1'b0;
      {s18, s22, ll, lg} = 4'b1101;
      repeat (200 * TB_TICK) @(negedge mclk);
      {s18, s22} = 2'b00;
      repeat (4) @(negedge mclk);
      outs(1'b0, 1'b0);
      slow = 1'b1;
      {s18, s22} = 2'b11;
      for (cyc = 0; cyc < 2200; cyc++) begin
         @(negedge mclk);
         if (sup_known(cyc)) outs(1'b0, sup_fault(cyc));
      end
      {s18, s22} = 2'b00;
      repeat (50) @(negedge mclk);
      outs(1'b0, 1'b1);
      press();
      outs(1'b0, 1'b0);
      slow = 1'b0;
      repeat (3100) @(negedge mclk);
      outs(1'b0, 1'b0);
      run = 1'b0;
      for (cyc = 0; cyc < 6100; cyc++) begin
         @(negedge mclk);
         if (cyc < 5900) outs(1'b0, 1'b0);
         else if (cyc >= 6008) outs(1'b1, 1'b0);
      end
      {ll, lg} = 2'b10;
      repeat ((INHIBIT_MS + 3) * TB_TICK) @(negedge mclk);
      chk("relay_coil", 1'b1, coil);
      chk("activity_fault_lamp", 1'b1, afl);
      run = 1'b1;
      {ll, lg} = 2'b01;
      repeat ((ENABLE_MS + 3) * TB_TICK) @(negedge mclk);
      chk("relay_coil", 1'b1, coil);
      chk("remote_fault_lamp", 1'b1, rfl);
      press();
      outs(1'b0, 1'b0);
      do_reset();
      test_done();
   end
   initial begin
      #2_500_000;
      n_fail++;
      test_done();
   end
endmodule // cam_monitor_tb_top
